/* core/npic_consts.svh */
// Constants of the nested priority interrupt controller
// Assumes inclusion by bare name from the package and the core
`ifndef NPIC_CONSTS_SVH
`define NPIC_CONSTS_SVH
// ----------------------------------------------------------------
// Register byte offsets on APB
// ----------------------------------------------------------------
`define NPIC_OFS_PRIO0 8'h00
`define NPIC_OFS_PRIO1 8'h04
`define NPIC_OFS_PRIO2 8'h08
`define NPIC_OFS_PRIO3 8'h0c
`define NPIC_OFS_ENABLE 8'h10
`define NPIC_OFS_PEND 8'h14
`define NPIC_OFS_FLAGS 8'h18
// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define NPIC_NSRC 14
`define NPIC_PRIO_RST 2'h3
`define NPIC_CODE_LVL0 2'h2
`define NPIC_CODE_LVL3 2'h3
`define NPIC_FLAG_HI_BIT 5
`define NPIC_FLAG_LO_BIT 3
`define NPIC_ENABLE_RST 14'h0000
`define NPIC_PRIO3_RO_BITS 4'hf
// ----------------------------------------------------------------
// Vector addresses and source numbers
// ----------------------------------------------------------------
`define NPIC_VEC_RESET 16'hfffe
`define NPIC_VEC_TRAP 16'hfffc
`define NPIC_VEC_TOP 16'hfffa
`define NPIC_SRC_TRAP 5'h0e
`define NPIC_SRC_RESET 5'h0f
`endif

/* core/npic_core.sv */
// Nested priority interrupt controller core with APB register access
// Assumes the sequencer samples svc_req_o only at instruction boundaries
// and pulses svc_ack_i once when stacking (or the reset fetch) begins
//
// Decided for this implementation: the address map and register access over APB.
`include "npic_consts.svh"

// Behaviour
// - Priority codes: level0=10, level1=01, level2=00, level3=11 disables interrupts.
// - Current priority pair sits at flags bits 5 and 3.
// - Sixteen vectors at fixed addresses FFE0h..FFFFh sorted by hardware priority.
// - Four programmable nesting levels; nested or concurrent handling.
// - Emergency stop is the one maskable top source; reset and trap non-maskable.
// - Current instruction completes before the flow is suspended.
// - Entry stacks program counter, index, accumulator and flags.
// - Entry loads current priority from the serviced vector's priority field; emergency stop loads level 3.
// - After stacking, vector goes to program counter and handler is fetched.
// - Interrupt return restores stacked priority bits to resume previous level.
// - Highest software priority wins; ties go to highest hardware priority.
// - Unserviced requests stay latched until their combined priority is highest.
// - Distinct hardware priorities always give exactly one winner.
// - Reset, trap and emergency stop outrank every software level.
// - Non-maskable sources ignore mask, load vector and set level 3.
// - Non-maskable sources wake the processor from halt.
// - Trap instruction raises trap, serviced like the emergency stop.
// - Reset is highest; routine after reset runs at level 3.
// - Maskable source served only if enabled and, except the emergency stop, above current level.
// - Hardware order rises: main, sources 13..1, emergency stop (source 0), trap, reset highest.
// - Writing the level0 code to a priority field keeps the old value.
module npic_core
  import npic_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Request sources, index 0 is the emergency stop
  input wire logic [13:0] irq_i,
  input wire logic trap_exec_i,
  // Sequencer side
  input wire logic instr_boundary_i,
  input wire logic halt_i,
  input wire logic svc_ack_i,
  input wire logic interrupt_return_i,
  input wire logic [1:0] restore_prio_i,
  input wire logic prio_wr_i,
  input wire logic [1:0] prio_wdata_i,
  output logic svc_req_o,
  output npic_svc_t svc_o,
  output logic wake_o,
  output logic prio_bit_high_o,
  output logic prio_bit_low_o
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [1:0] vector_priority_regs [`NPIC_NSRC];
  logic [13:0] enable_q;
  logic [13:0] pend_q;
  logic trap_pend_q;
  logic reset_pend_q;
  logic [1:0] prio_q;
  npic_state_t state_q;
  npic_state_t state_d;
  npic_svc_t svc_q;
  npic_svc_t svc_d;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire apb_wr = psel_i && penable_i && pwrite_i;
  wire hit_prio = (paddr_i[7:4] == 4'h0) && (paddr_i[1:0] == 2'h0);
  wire hit_en = (paddr_i == `NPIC_OFS_ENABLE);
  wire hit_pend = (paddr_i == `NPIC_OFS_PEND);
  wire hit_flags = (paddr_i == `NPIC_OFS_FLAGS);
  wire [1:0] prio_reg = paddr_i[3:2];
  wire mapped = hit_prio || hit_en || hit_pend || hit_flags;
  wire [7:0] cpu_flags_register = {2'h0, prio_q[1], 1'b0, prio_q[0], 3'h0};
  logic [7:0] prio_rd;

  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && !mapped;

  always_comb begin
    prio_rd = 8'h00;
    for (int k = 0; k < 4; k++) begin
      if (int'(prio_reg) * 4 + k < `NPIC_NSRC) begin
        prio_rd[2*k +: 2] = vector_priority_regs[int'(prio_reg) * 4 + k];
      end else begin
        prio_rd[2*k +: 2] = 2'h3;
      end
    end
  end

  always_comb begin
    prdata_o = 32'h0000_0000;
    if (hit_prio) begin
      prdata_o = {24'h00_0000, prio_rd};
    end else if (hit_en) begin
      prdata_o = {18'h0_0000, enable_q};
    end else if (hit_pend) begin
      prdata_o = {16'h0000, reset_pend_q, trap_pend_q, pend_q};
    end else if (hit_flags) begin
      prdata_o = {24'h00_0000, cpu_flags_register};
    end
  end

  // ----------------------------------------------------------------
  // Per-vector priority fields
  // ----------------------------------------------------------------
  // Level 0 cannot be stored, so a vector can never sit below main
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < `NPIC_NSRC; i++) begin
        vector_priority_regs[i] <= `NPIC_PRIO_RST;
      end
    end else if (apb_wr && hit_prio) begin
      for (int k = 0; k < 4; k++) begin
        if (int'(prio_reg) * 4 + k < `NPIC_NSRC &&
            pwdata_i[2*k +: 2] != `NPIC_CODE_LVL0) begin
          vector_priority_regs[int'(prio_reg) * 4 + k] <= pwdata_i[2*k +: 2];
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enable_q <= `NPIC_ENABLE_RST;
    end else if (apb_wr && hit_en) begin
      enable_q <= pwdata_i[13:0];
    end
  end

  // ----------------------------------------------------------------
  // Pending latches
  // ----------------------------------------------------------------
  wire ack_take = (state_q == NPIC_ST_OFFER) && svc_ack_i && instr_boundary_i;
  logic [13:0] pend_clr;

  always_comb begin
    pend_clr = 14'h0000;
    if (ack_take && svc_q.src < 5'(`NPIC_NSRC)) begin
      pend_clr[svc_q.src[3:0]] = 1'b1;
    end
  end

  // A new request in the clearing cycle survives
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend_q <= 14'h0000;
    end else begin
      pend_q <= (pend_q & ~pend_clr) | irq_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trap_pend_q <= 1'b0;
    end else if (trap_exec_i) begin
      trap_pend_q <= 1'b1;
    end else if (ack_take && svc_q.src == `NPIC_SRC_TRAP) begin
      trap_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reset_pend_q <= 1'b1;
    end else if (ack_take && svc_q.src == `NPIC_SRC_RESET) begin
      reset_pend_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Arbitration
  // ----------------------------------------------------------------
  wire [2:0] cur_lvl = npic_level(prio_q);
  logic [13:0] eligible;
  logic found;
  logic [3:0] best_idx;
  logic [2:0] best_lvl;

  always_comb begin
    for (int i = 0; i < `NPIC_NSRC; i++) begin
      if (i == 0) begin
        eligible[i] = pend_q[i] && enable_q[i];
      end else begin
        eligible[i] = pend_q[i] && enable_q[i] &&
                      (npic_level(vector_priority_regs[i]) > cur_lvl);
      end
    end
  end

  // Walk from lowest hardware rank upward; >= lets the higher rank take ties
  always_comb begin
    found = 1'b0;
    best_idx = 4'h0;
    best_lvl = 3'h0;
    for (int i = `NPIC_NSRC - 1; i >= 0; i--) begin
      if (eligible[i] && (!found || (i == 0 ? 3'h4 : npic_level(vector_priority_regs[i])) >= best_lvl)) begin
        found = 1'b1;
        best_idx = 4'(i);
        best_lvl = (i == 0) ? 3'h4 : npic_level(vector_priority_regs[i]);
      end
    end
  end

  wire any_win = reset_pend_q || trap_pend_q || found;

  always_comb begin
    svc_d = svc_q;
    if (reset_pend_q) begin
      svc_d.vec = `NPIC_VEC_RESET;
      svc_d.prio = `NPIC_CODE_LVL3;
      svc_d.stack = 1'b0;
      svc_d.src = `NPIC_SRC_RESET;
    end else if (trap_pend_q) begin
      svc_d.vec = `NPIC_VEC_TRAP;
      svc_d.prio = `NPIC_CODE_LVL3;
      svc_d.stack = 1'b1;
      svc_d.src = `NPIC_SRC_TRAP;
    end else if (found) begin
      svc_d.vec = `NPIC_VEC_TOP - {11'h000, best_idx, 1'b0};
      svc_d.prio = (best_idx == 4'h0) ? `NPIC_CODE_LVL3 : vector_priority_regs[best_idx];
      svc_d.stack = 1'b1;
      svc_d.src = {1'b0, best_idx};
    end
  end

  // ----------------------------------------------------------------
  // Offer state machine
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      NPIC_ST_IDLE: begin
        if (any_win) begin
          state_d = NPIC_ST_OFFER;
        end
      end
      NPIC_ST_OFFER: begin
        if (ack_take || !any_win) begin
          state_d = NPIC_ST_IDLE;
        end
      end
      default: state_d = NPIC_ST_IDLE;
    endcase
  end

  // Offer is refreshed until taken, so a later higher request overtakes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= NPIC_ST_IDLE;
      svc_q <= '0;
    end else begin
      state_q <= state_d;
      if (!ack_take) begin
        svc_q <= svc_d;
      end
    end
  end

  assign svc_req_o = (state_q == NPIC_ST_OFFER) && instr_boundary_i;
  assign svc_o = svc_q;
  assign wake_o = halt_i && (reset_pend_q || trap_pend_q);

  // ----------------------------------------------------------------
  // Current priority pair
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prio_q <= `NPIC_PRIO_RST;
    end else if (ack_take) begin
      prio_q <= svc_q.prio;
    end else if (interrupt_return_i) begin
      prio_q <= restore_prio_i;
    end else if (prio_wr_i) begin
      prio_q <= prio_wdata_i;
    end
  end

  assign prio_bit_high_o = prio_q[1];
  assign prio_bit_low_o = prio_q[0];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_taken;
    svc_req_o && svc_ack_i;
  endsequence

  sequence s_prio_loaded;
    ##1 (prio_q == $past(svc_q.prio));
  endsequence

  property p_prio_on_entry;
    @(posedge clk_i) disable iff (!rst_n_i)
    s_taken |-> s_prio_loaded;
  endproperty
  a_prio_on_entry: assert property (p_prio_on_entry) else $error("priority not loaded on entry");

  property p_reset_first;
    @(posedge clk_i) disable iff (!rst_n_i)
    (svc_req_o && reset_pend_q) |-> (svc_o.vec == 16'hfffe && !svc_o.stack && svc_o.prio == 2'h3);
  endproperty
  a_reset_first: assert property (p_reset_first) else $error("reset offer wrong");

  property p_nmi_level3;
    @(posedge clk_i) disable iff (!rst_n_i)
    (svc_req_o && svc_o.src >= 5'h0e) |-> (svc_o.prio == 2'h3);
  endproperty
  a_nmi_level3: assert property (p_nmi_level3) else $error("non-maskable not at level 3");

  property p_masked_above;
    @(posedge clk_i) disable iff (!rst_n_i)
    (svc_req_o && svc_o.src != 5'h00 && svc_o.src < 5'h0e && !svc_ack_i)
      |-> (npic_level(svc_o.prio) > cur_lvl || $changed(prio_q));
  endproperty
  a_masked_above: assert property (p_masked_above) else $error("masked source offered");

  property p_interrupt_return_restore;
    @(posedge clk_i) disable iff (!rst_n_i)
    (interrupt_return_i && !ack_take) |=> (prio_q == $past(restore_prio_i));
  endproperty
  a_interrupt_return_restore: assert property (p_interrupt_return_restore) else $error("return did not restore priority");

  property p_level0_kept;
    @(posedge clk_i) disable iff (!rst_n_i)
    (apb_wr && paddr_i == `NPIC_OFS_PRIO0 && pwdata_i[5:4] == `NPIC_CODE_LVL0)
      |=> (vector_priority_regs[2] == $past(vector_priority_regs[2]));
  endproperty
  a_level0_kept: assert property (p_level0_kept) else $error("level 0 code stored");

  property p_latched;
    @(posedge clk_i) disable iff (!rst_n_i)
    irq_i[1] |=> pend_q[1] [*2] or (pend_q[1] ##1 $past(ack_take));
  endproperty
  a_latched: assert property (p_latched) else $error("request not latched");

  property p_boundary;
    @(posedge clk_i) disable iff (!rst_n_i)
    (!instr_boundary_i && !interrupt_return_i && !prio_wr_i) |=> $stable(prio_q);
  endproperty
  a_boundary: assert property (p_boundary) else $error("priority changed off boundary");

  property p_wake;
    @(posedge clk_i) disable iff (!rst_n_i)
    (halt_i && trap_exec_i) |=> wake_o;
  endproperty
  a_wake: assert property (p_wake) else $error("trap did not wake");

  property p_vector_map;
    @(posedge clk_i) disable iff (!rst_n_i)
    (svc_req_o && svc_o.src < 5'h0e) |-> (svc_o.vec == 16'hfffa - {10'h000, svc_o.src, 1'b0});
  endproperty
  a_vector_map: assert property (p_vector_map) else $error("vector address wrong");
endmodule

/* core/npic_pkg.sv */
// Types of the nested priority interrupt controller
// Assumes the constants header sits in the include path
`include "npic_consts.svh"
package npic_pkg;
  typedef enum logic [1:0] {
    NPIC_ST_IDLE = 2'h0,
    NPIC_ST_OFFER = 2'h1
  } npic_state_t;

  // One service offer to the sequencer
  typedef struct packed {
    logic [15:0] vec;
    logic [1:0] prio;
    logic stack;
    logic [4:0] src;
  } npic_svc_t;

  // Code in the flags pair to nesting level 0..3
  function automatic logic [2:0] npic_level(input logic [1:0] code);
    logic [2:0] lvl;
    lvl = 3'h0;
    case (code)
      2'h2: lvl = 3'h0;
      2'h1: lvl = 3'h1;
      2'h0: lvl = 3'h2;
      default: lvl = 3'h3;
    endcase
    return lvl;
  endfunction
endpackage

/* verif/npic_seq_model.sv */
// Sequencer model facing the interrupt controller core
// Assumes the bench drives hold_i and ret_i just after rising edges
module npic_seq_model
  import npic_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Bench control
  input wire logic hold_i,
  input wire logic ret_i,
  // Controller side
  input wire logic svc_req_i,
  input wire npic_svc_t svc_i,
  input wire logic prio_hi_i,
  input wire logic prio_lo_i,
  output logic boundary_o,
  output logic ack_o,
  output logic ret_o,
  output logic [1:0] restore_o,
  // Record of services
  output npic_svc_t last_o,
  output logic [7:0] cnt_o
);
  logic [1:0] stack_q [0:7];
  logic [2:0] sp_q;
  wire taken = svc_req_i && ack_o;
  // A held instruction keeps the boundary low
  assign boundary_o = !hold_i;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o <= 1'b0;
      ret_o <= 1'b0;
      restore_o <= 2'h0;
      last_o <= '0;
      cnt_o <= 8'h00;
      sp_q <= 3'h0;
    end else begin
      // Acknowledge one cycle into the offer, as stacking starts
      ack_o <= svc_req_i && !ack_o;
      ret_o <= 1'b0;
      if (taken) begin
        last_o <= svc_i;
        cnt_o <= cnt_o + 8'h01;
        if (svc_i.stack) begin
          // Flags pair stacked with the other context
          stack_q[sp_q] <= {prio_hi_i, prio_lo_i};
          sp_q <= sp_q + 3'h1;
        end
      end else if (ret_i) begin
        // Return pops the previous pair
        ret_o <= 1'b1;
        restore_o <= stack_q[sp_q - 3'h1];
        sp_q <= sp_q - 3'h1;
      end
    end
  end
endmodule

/* verif/tb.sv */
// Self-checking bench for the interrupt controller core
// Assumes the sequencer model answers every offer and pops on request
`include "npic_consts.svh"
module tb
  import npic_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_n_i, psel, penable, pwrite, trap, halt, prio_wr, hold, ret;
  logic pready, pslverr, svc_req, bnd, ack, ret_p, wake, hi, lo, err;
  logic [7:0] paddr, cnt, c0;
  logic [31:0] pwdata, prdata, rd;
  logic [13:0] irq;
  logic [1:0] prio_wd, restore;
  npic_svc_t svc, last;
  int failures, checks, cycles;
  npic_core dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .irq_i(irq), .trap_exec_i(trap), .instr_boundary_i(bnd), .halt_i(halt),
    .svc_ack_i(ack), .interrupt_return_i(ret_p), .restore_prio_i(restore), .prio_wr_i(prio_wr),
    .prio_wdata_i(prio_wd), .svc_req_o(svc_req), .svc_o(svc), .wake_o(wake),
    .prio_bit_high_o(hi), .prio_bit_low_o(lo));
  npic_seq_model model_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .hold_i(hold), .ret_i(ret),
    .svc_req_i(svc_req), .svc_i(svc), .prio_hi_i(hi), .prio_lo_i(lo), .boundary_o(bnd),
    .ack_o(ack), .ret_o(ret_p), .restore_o(restore), .last_o(last), .cnt_o(cnt));
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Ceiling well above the few hundred cycles the tests need
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1) @(posedge clk_i);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic e);
    xfer(1'b0, a, 32'h0);
    chk("apb_rdata", rd, exp);
    chk("apb_err", {31'h0, err}, {31'h0, e});
  endtask
  task automatic serve(input logic [15:0] v, input logic [1:0] p, input logic [4:0] s, input logic st);
    int n;
    n = 0;
    c0 = cnt;
    while (cnt === c0 && n < 60) begin
      @(negedge clk_i);
      n++;
    end
    chk("svc_count", {24'h0, cnt}, {24'h0, c0 + 8'h01});
    chk("svc_vec", {16'h0, last.vec}, {16'h0, v});
    chk("svc_src", {27'h0, last.src}, {27'h0, s});
    chk("svc_stack", {31'h0, last.stack}, {31'h0, st});
    chk("pair", {30'h0, hi, lo}, {30'h0, p});
  endtask
  task automatic idle_none();
    c0 = cnt;
    repeat (8) @(negedge clk_i);
    chk("no_service", {24'h0, cnt}, {24'h0, c0});
  endtask
  task automatic pop(input logic [1:0] p);
    @(posedge clk_i) ret <= 1'b1;
    @(posedge clk_i) ret <= 1'b0;
    repeat (2) @(negedge clk_i);
    chk("pair_ret", {30'h0, hi, lo}, {30'h0, p});
  endtask
  task automatic pulse(input logic [13:0] m);
    @(posedge clk_i) irq <= m;
    @(posedge clk_i) irq <= 14'h0;
  endtask
  task automatic setp(input logic [1:0] v);
    @(posedge clk_i) begin
      prio_wr <= 1'b1;
      prio_wd <= v;
    end
    @(posedge clk_i) prio_wr <= 1'b0;
    @(negedge clk_i);
    chk("pair_wr", {30'h0, hi, lo}, {30'h0, v});
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {rst_n_i, psel, penable, pwrite, trap, halt, prio_wr, hold, ret} = '0;
    {paddr, pwdata, irq, prio_wd, failures, checks, cycles} = '0;
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    serve(`NPIC_VEC_RESET, 2'h3, `NPIC_SRC_RESET, 1'b0);
    rdc(`NPIC_OFS_PRIO0, 32'hff, 1'b0);
    rdc(`NPIC_OFS_ENABLE, 32'h0, 1'b0);
    rdc(`NPIC_OFS_FLAGS, 32'h28, 1'b0);
    rdc(8'h1c, 32'h0, 1'b1);
    xfer(1'b1, `NPIC_OFS_PRIO0, 32'hcf);
    xfer(1'b1, `NPIC_OFS_PRIO0, 32'h64);
    rdc(`NPIC_OFS_PRIO0, 32'h44, 1'b0);
    xfer(1'b1, `NPIC_OFS_PRIO1, 32'hf7);
    xfer(1'b1, `NPIC_OFS_PRIO3, 32'h07);
    rdc(`NPIC_OFS_PRIO3, 32'hf7, 1'b0);
    setp(2'h2);
    rdc(`NPIC_OFS_FLAGS, 32'h20, 1'b0);
    $display("test registers done");
    pulse(14'h0008);
    idle_none();
    rdc(`NPIC_OFS_PEND, 32'h8, 1'b0);
    @(posedge clk_i) hold <= 1'b1;
    xfer(1'b1, `NPIC_OFS_ENABLE, 32'h28);
    pulse(14'h0020);
    @(posedge clk_i) hold <= 1'b0;
    serve(16'hfff4, 2'h1, 5'h03, 1'b1);
    idle_none();
    rdc(`NPIC_OFS_PEND, 32'h20, 1'b0);
    pop(2'h2);
    serve(16'hfff0, 2'h1, 5'h05, 1'b1);
    pop(2'h2);
    $display("test hardware order done");
    @(posedge clk_i) hold <= 1'b1;
    xfer(1'b1, `NPIC_OFS_ENABLE, 32'h06);
    pulse(14'h0006);
    @(posedge clk_i) hold <= 1'b0;
    serve(16'hfff6, 2'h0, 5'h02, 1'b1);
    idle_none();
    @(posedge clk_i) begin
      hold <= 1'b1;
      halt <= 1'b1;
    end
    @(posedge clk_i) trap <= 1'b1;
    @(posedge clk_i) trap <= 1'b0;
    @(negedge clk_i);
    chk("wake", {31'h0, wake}, 32'h1);
    @(posedge clk_i) begin
      hold <= 1'b0;
      halt <= 1'b0;
    end
    serve(`NPIC_VEC_TRAP, 2'h3, `NPIC_SRC_TRAP, 1'b1);
    pop(2'h0);
    pop(2'h2);
    serve(16'hfff8, 2'h1, 5'h01, 1'b1);
    pop(2'h2);
    $display("test nesting and trap done");
    xfer(1'b1, `NPIC_OFS_ENABLE, 32'h2000);
    pulse(14'h2000);
    serve(16'hffe0, 2'h1, 5'h0d, 1'b1);
    pop(2'h2);
    setp(2'h3);
    xfer(1'b1, `NPIC_OFS_ENABLE, 32'h1);
    pulse(14'h0001);
    serve(`NPIC_VEC_TOP, 2'h3, 5'h00, 1'b1);
    pop(2'h3);
    $display("test vectors and emergency stop done");
    wrap_up();
  end
endmodule
